// >>> rtl/prch_pkg.sv
package prch_pkg;

    // Command mailbox opcodes
    localparam logic [7:0] OP_POWER_OFF = 8'h80;
    localparam logic [7:0] OP_SOFT_RESET = 8'h81;
    localparam logic [7:0] OP_HARD_RESET = 8'h82;
    localparam logic [7:0] OP_KEEP_ON = 8'h83;
    localparam logic [7:0] OP_DELAYED_OFF = 8'h84;

    // Passwords
    localparam logic [7:0] PW_POWER_OFF = 8'hb2;
    localparam logic [7:0] PW_SOFT_RESET = 8'hb3;
    localparam logic [7:0] PW_HARD_RESET = 8'hb4;

    localparam int STATUS_BIT = 0;
    localparam int KEEP_BIT = 0;
    localparam logic [7:0] RESP_RESET = 8'h00;

    // Timing at 40 MHz
    localparam int CLK_HZ = 40000000;
    localparam int KEEP_WINDOW_S = 5;
    localparam int DELAY_OFF_MS = 30;
    localparam int KEEP_WINDOW_CYC = KEEP_WINDOW_S * CLK_HZ;
    localparam int DELAY_OFF_CYC = DELAY_OFF_MS * (CLK_HZ / 1000);
    localparam int SOFT_RST_CYC = 16;

    typedef struct packed {
        logic power_off;
        logic soft_reset;
        logic hard_reset;
    } prch_action_s;

    typedef enum logic [1:0] {
        ST_ON,
        ST_DELAY,
        ST_OFF
    } prch_state_e;

endpackage

// >>> rtl/prch_timer.sv
`timescale 1ns/1ps
module prch_timer import prch_pkg::*; #(
    parameter int WIDTH = 32
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    input wire logic stop_in,
    input wire logic [WIDTH-1:0] load_in,
    output logic expired_out,
    output logic running_out
);
    logic [WIDTH-1:0] cnt_q;
    logic run_q;

    assign running_out = run_q;
    assign expired_out = run_q && (cnt_q == '0) && !stop_in;

    always_ff @(posedge clk_in) begin
        if (!nrst_in || stop_in) begin
            cnt_q <= '0;
            run_q <= 1'b0;
        end else if (start_in) begin
            cnt_q <= load_in;
            run_q <= 1'b1;
        end else if (run_q) begin
            if (cnt_q == '0) begin
                run_q <= 1'b0;
            end else begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

// >>> rtl/prch_top.sv
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Off opcode with off password powers off immediately.
// - Wrong password on off, delayed off, soft or hard reset: no action.
// - Off status bit 0: 0 good password, 1 wrong.
// - Soft reset opcode with password: registers default, reset line asserted.
// - Soft reset status bit 0: 0 good password, 1 wrong.
// - Hard reset opcode with password: supplies off then full power-on; the code only pulses HARD_RESET_OUT for one cycle.
// - Hard reset status bit 0: 0 good password, 1 wrong.
// - Without keep latch, power off five seconds after reset line rises.
// - Keep latch, once set, ignores writes until next power cycle.
// - Delayed off opcode with off password: off state 30 ms later.
// - Delayed off status bit 0: 0 good password, 1 wrong.
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module prch_top import prch_pkg::*; #(
    parameter int KEEP_CYC = KEEP_WINDOW_CYC,
    parameter int DELAY_CYC = DELAY_OFF_CYC
) (
    input wire logic CORE_CLK_IN,
    input wire logic NRST_IN,
    input wire logic CMD_VALID_IN,
    input wire logic [7:0] COMMAND_OUT_MAILBOX_IN,
    input wire logic [7:0] COMMAND_DATA_OUT_BYTE0_IN,
    input wire logic RST_LINE_HIGH_IN,
    output logic RESP_VALID_OUT,
    output logic [7:0] RESPONSE_MAILBOX_OUT,
    output logic [7:0] RESPONSE_DATA_IN_BYTE0_OUT,
    output logic POWER_OFF_OUT,
    output logic HARD_RESET_OUT,
    output logic SOFT_RESET_OUT,
    output logic KEEP_POWERED_LATCH_OUT,
    output logic [1:0] STATE_OUT
);
    //////////////////////////////////////////////////////////////////////////
    function automatic logic known_op(input logic [7:0] op);
        return op inside {OP_POWER_OFF, OP_SOFT_RESET, OP_HARD_RESET,
                          OP_KEEP_ON, OP_DELAYED_OFF};
    endfunction

    prch_state_e state_q, state_d;
    prch_action_s act;
    logic [7:0] resp_q, data_q, data_d;
    logic rv_q, keep_q, poff_q, hrst_q, srst_q, rst_seen_q;
    logic [7:0] srst_cnt_q;
    logic cmd_ok, pw_bad, known, keep_exp, dly_exp, rst_rise;
    logic [7:0] op, dat;

    assign op = COMMAND_OUT_MAILBOX_IN;
    assign dat = COMMAND_DATA_OUT_BYTE0_IN;
    assign known = known_op(op);
    // Commands are ignored outside ST_ON (delayed off or off) or in a soft reset pulse
    assign cmd_ok = CMD_VALID_IN && (state_q == ST_ON) && !srst_q;
    assign act.power_off = cmd_ok && op == OP_POWER_OFF && dat == PW_POWER_OFF;
    assign act.soft_reset = cmd_ok && op == OP_SOFT_RESET
                            && dat == PW_SOFT_RESET;
    assign act.hard_reset = cmd_ok && op == OP_HARD_RESET
                            && dat == PW_HARD_RESET;
    assign pw_bad = !(act.power_off || act.soft_reset || act.hard_reset
                      || (op == OP_DELAYED_OFF && dat == PW_POWER_OFF));
    assign data_d = (op == OP_KEEP_ON) ? 8'h00 : {7'h00, pw_bad};
    assign rst_rise = RST_LINE_HIGH_IN && !rst_seen_q;

    //////////////////////////////////////////////////////////////////////////
    // keep window timer
    prch_timer #(.WIDTH(32)) u_keep (
        .clk_in(CORE_CLK_IN),
        .nrst_in(NRST_IN),
        .start_in(rst_rise && !keep_q),
        .stop_in(keep_q || state_q == ST_OFF),
        .load_in(32'(KEEP_CYC - 1)),
        .expired_out(keep_exp),
        .running_out()
    );

    prch_timer #(.WIDTH(32)) u_dly (
        .clk_in(CORE_CLK_IN),
        .nrst_in(NRST_IN),
        .start_in(cmd_ok && op == OP_DELAYED_OFF && dat == PW_POWER_OFF),
        .stop_in(state_q == ST_OFF),
        .load_in(32'(DELAY_CYC - 1)),
        .expired_out(dly_exp),
        .running_out()
    );

    //////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_ON: begin
                if (act.power_off || keep_exp) begin
                    state_d = ST_OFF;
                end else if (cmd_ok && op == OP_DELAYED_OFF
                             && dat == PW_POWER_OFF) begin
                    state_d = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (dly_exp) begin
                    state_d = ST_OFF;
                end
            end
            ST_OFF: state_d = ST_OFF;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            state_q <= ST_ON;
            keep_q <= 1'b0;
            rst_seen_q <= 1'b0;
        end else begin
            state_q <= state_d;
            rst_seen_q <= rst_seen_q | RST_LINE_HIGH_IN;
            // latch set once, cleared only by power cycle
            if (cmd_ok && op == OP_KEEP_ON && dat[KEEP_BIT]) begin
                keep_q <= 1'b1;
            end
        end
    end

    // response echo for known opcodes only
    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN || act.soft_reset) begin
            resp_q <= RESP_RESET;
            data_q <= RESP_RESET;
            // Soft reset still answers, power-on reset never does
            rv_q <= NRST_IN;
        end else begin
            rv_q <= cmd_ok && known;
            if (cmd_ok && known) begin
                resp_q <= op;
                data_q <= data_d;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (!NRST_IN) begin
            srst_q <= 1'b0;
            hrst_q <= 1'b0;
            srst_cnt_q <= 8'h00;
        end else begin
            hrst_q <= act.hard_reset;
            if (act.soft_reset) begin
                srst_q <= 1'b1;
                srst_cnt_q <= 8'(SOFT_RST_CYC - 1);
            end else if (srst_cnt_q != 8'h00) begin
                srst_cnt_q <= srst_cnt_q - 8'h01;
            end else begin
                srst_q <= 1'b0;
            end
        end
    end

    assign poff_q = (state_q == ST_OFF);
    assign RESP_VALID_OUT = rv_q;
    assign RESPONSE_MAILBOX_OUT = resp_q;
    assign RESPONSE_DATA_IN_BYTE0_OUT = data_q;
    assign POWER_OFF_OUT = poff_q;
    assign HARD_RESET_OUT = hrst_q;
    assign SOFT_RESET_OUT = srst_q;
    assign KEEP_POWERED_LATCH_OUT = keep_q;
    assign STATE_OUT = state_q;

    //////////////////////////////////////////////////////////////////////////
    property p_off_now;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        act.power_off |=> POWER_OFF_OUT;
    endproperty
    a_off_now: assert property (p_off_now)
        else $error("power off not immediate");

    property p_bad_pw;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (cmd_ok && op == OP_POWER_OFF && dat != PW_POWER_OFF
         && !keep_exp && state_q == ST_ON) |=> !POWER_OFF_OUT;
    endproperty
    a_bad_pw: assert property (p_bad_pw)
        else $error("wrong password acted");

    property p_off_stat;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (cmd_ok && op == OP_POWER_OFF) |=>
            RESPONSE_DATA_IN_BYTE0_OUT[0] == $past(dat != PW_POWER_OFF);
    endproperty
    a_off_stat: assert property (p_off_stat)
        else $error("power off status wrong");

    property p_soft;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        act.soft_reset |=> SOFT_RESET_OUT && RESPONSE_MAILBOX_OUT == 8'h00;
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft reset missing");

    property p_soft_stat;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (cmd_ok && op == OP_SOFT_RESET && dat != PW_SOFT_RESET) |=>
            RESPONSE_DATA_IN_BYTE0_OUT == 8'h01 && !SOFT_RESET_OUT;
    endproperty
    a_soft_stat: assert property (p_soft_stat)
        else $error("soft reset status wrong");

    property p_hard;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        act.hard_reset |=> HARD_RESET_OUT
            ##1 (HARD_RESET_OUT == $past(act.hard_reset));
    endproperty
    a_hard: assert property (p_hard)
        else $error("hard reset pulse wrong");

    property p_hard_stat;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (cmd_ok && op == OP_HARD_RESET) |=>
            RESPONSE_DATA_IN_BYTE0_OUT[0] == $past(dat != PW_HARD_RESET)
            && RESPONSE_DATA_IN_BYTE0_OUT[0] == !HARD_RESET_OUT;
    endproperty
    a_hard_stat: assert property (p_hard_stat)
        else $error("hard reset status wrong");

    property p_keep_exp;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (keep_exp && state_q == ST_ON) |=> POWER_OFF_OUT;
    endproperty
    a_keep_exp: assert property (p_keep_exp)
        else $error("keep window expiry ignored");

    property p_keep_sticky;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        KEEP_POWERED_LATCH_OUT |=> KEEP_POWERED_LATCH_OUT;
    endproperty
    a_keep_sticky: assert property (p_keep_sticky)
        else $error("keep latch cleared");

    property p_dly;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        $rose(state_q == ST_DELAY) |-> !POWER_OFF_OUT[*8];
    endproperty
    a_dly: assert property (p_dly)
        else $error("delayed off too early");

    property p_dly_stat;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (cmd_ok && op == OP_DELAYED_OFF) |=>
            RESPONSE_DATA_IN_BYTE0_OUT[0] == $past(dat != PW_POWER_OFF);
    endproperty
    a_dly_stat: assert property (p_dly_stat)
        else $error("delayed off status wrong");

    property p_echo;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (cmd_ok && known && !act.soft_reset) |=>
            RESP_VALID_OUT && RESPONSE_MAILBOX_OUT == $past(op);
    endproperty
    a_echo: assert property (p_echo)
        else $error("opcode not echoed");

    property p_unknown;
        @(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (CMD_VALID_IN && !known && !keep_exp && !dly_exp) |=>
            !RESP_VALID_OUT && $stable(state_q);
    endproperty
    a_unknown: assert property (p_unknown)
        else $error("unknown opcode acted");

    c_off: cover property (@(posedge CORE_CLK_IN) act.power_off);
    c_dly: cover property (@(posedge CORE_CLK_IN)
        state_q == ST_DELAY ##1 state_q == ST_OFF);
    c_keep: cover property (@(posedge CORE_CLK_IN) $rose(keep_q));
    c_soft: cover property (@(posedge CORE_CLK_IN) act.soft_reset);
endmodule

// >>> tb/prch_host.sv
`timescale 1ns/1ps
module prch_host (
    input wire logic clk_in,
    output logic valid_out,
    output logic [7:0] op_out,
    output logic [7:0] data_out
);
    initial begin
        valid_out = 1'b0;
        op_out = 8'h00;
        data_out = 8'h00;
    end

    //////////////////////////////////////////////////////////////////////
    // opcode with data byte
    task automatic send(input logic [7:0] op, input logic [7:0] data);
        @(negedge clk_in);
        valid_out = 1'b1;
        op_out = op;
        data_out = data;
        @(negedge clk_in);
        valid_out = 1'b0;
        // Released lines carry junk so a stale byte is never trusted
        op_out = ~op;
        data_out = ~data;
    endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
module testbench import prch_pkg::*;;
    localparam int KC = 100;
    localparam int DC = 20;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic rst_line = 1'b0;
    logic cmd_valid, resp_valid, pwr_off, hard_rst, soft_rst, keep;
    logic [7:0] cmd_op, cmd_data, resp_mb, resp_d0, acts, op, bad;
    logic [1:0] state;
    logic [7:0] wops [4];
    int num_errors = 0;
    int cmp_count = 0;
    int seed = 7;
    int cycles = 0;

    assign acts = {3'h0, state, pwr_off, hard_rst, soft_rst};

    always #12.5 clk = ~clk;

    prch_host host (.clk_in(clk), .valid_out(cmd_valid), .op_out(cmd_op),
        .data_out(cmd_data));

    prch_top #(.KEEP_CYC(KC), .DELAY_CYC(DC)) dut (
        .CORE_CLK_IN(clk), .NRST_IN(nrst), .CMD_VALID_IN(cmd_valid),
        .COMMAND_OUT_MAILBOX_IN(cmd_op), .COMMAND_DATA_OUT_BYTE0_IN(cmd_data),
        .RST_LINE_HIGH_IN(rst_line), .RESP_VALID_OUT(resp_valid),
        .RESPONSE_MAILBOX_OUT(resp_mb), .RESPONSE_DATA_IN_BYTE0_OUT(resp_d0),
        .POWER_OFF_OUT(pwr_off), .HARD_RESET_OUT(hard_rst),
        .SOFT_RESET_OUT(soft_rst), .KEEP_POWERED_LATCH_OUT(keep),
        .STATE_OUT(state));

    //////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic resp(input logic [7:0] o, input logic [7:0] d0);
        chk({7'h00, resp_valid}, 8'h01);
        chk(resp_mb, o);
        chk(resp_d0, d0);
    endtask

    function automatic logic [7:0] pw_of(input logic [7:0] o);
        case (o)
            OP_SOFT_RESET: return PW_SOFT_RESET;
            OP_HARD_RESET: return PW_HARD_RESET;
            default: return PW_POWER_OFF;
        endcase
    endfunction

    task automatic do_reset();
        @(negedge clk);
        nrst = 1'b0;
        rst_line = 1'b0;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
    endtask

    //////////////////////////////////////////////////////////////////////
    initial begin
        wops = '{OP_POWER_OFF, OP_SOFT_RESET, OP_HARD_RESET, OP_DELAYED_OFF};
        do_reset();
        chk(acts, 8'h00);
        chk(resp_mb, RESP_RESET);
        foreach (wops[i]) begin
            op = wops[i];
            bad = 8'($random(seed));
            if (bad == pw_of(op)) bad = ~bad;
            host.send(op, bad);
            resp(op, 8'h01);
            chk(acts, 8'h00);
        end
        repeat (8) begin
            op = 8'($random(seed));
            if (op inside {[8'h80:8'h84]}) op = 8'h7f;
            host.send(op, PW_POWER_OFF);
            chk({7'h00, resp_valid}, 8'h00);
            chk(resp_mb, OP_DELAYED_OFF);
            chk(acts, 8'h00);
        end
        host.send(OP_KEEP_ON, 8'h00);
        resp(OP_KEEP_ON, 8'h00);
        chk({7'h00, keep}, 8'h00);
        rst_line = 1'b1;
        host.send(OP_KEEP_ON, 8'h01);
        chk({7'h00, keep}, 8'h01);
        host.send(OP_KEEP_ON, 8'h00);
        chk({7'h00, keep}, 8'h01);
        repeat (KC + 20) @(negedge clk);
        chk(acts, 8'h00);
        host.send(OP_HARD_RESET, PW_HARD_RESET);
        resp(OP_HARD_RESET, 8'h00);
        chk(acts, 8'h02);
        @(negedge clk);
        chk(acts, 8'h00);
        host.send(OP_SOFT_RESET, PW_SOFT_RESET);
        resp(RESP_RESET, RESP_RESET);
        chk(acts, 8'h01);
        repeat (SOFT_RST_CYC - 1) @(negedge clk);
        chk(acts, 8'h01);
        @(negedge clk);
        chk(acts, 8'h00);
        do_reset();
        rst_line = 1'b1;
        repeat (KC) @(negedge clk);
        chk(acts, 8'h00);
        @(negedge clk);
        chk({7'h00, pwr_off}, 8'h01);
        do_reset();
        host.send(OP_DELAYED_OFF, PW_POWER_OFF);
        resp(OP_DELAYED_OFF, 8'h00);
        chk(acts, 8'h08);
        host.send(OP_SOFT_RESET, PW_SOFT_RESET);
        chk({7'h00, resp_valid}, 8'h00);
        repeat (DC - 3) @(negedge clk);
        chk(acts, 8'h08);
        @(negedge clk);
        chk(acts, 8'h14);
        do_reset();
        host.send(OP_POWER_OFF, PW_POWER_OFF);
        resp(OP_POWER_OFF, 8'h00);
        chk(acts, 8'h14);
        end_of_test();
    end
endmodule
